/* rtl/clk_mode_pkg.sv */
// constants and types of the system clock and power mode controller
package clk_mode_pkg;

    // =========================================================
    // clock rate and oscillator rates
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned FAST_2M_HZ = 2_000_000;
    localparam int unsigned FAST_4M_HZ = 4_000_000;
    localparam int unsigned FAST_8M_HZ = 8_000_000;
    localparam int unsigned SLOW_OSC_HZ = 32_000;
    localparam int unsigned OSC_DIV_W = 11;
    localparam logic [OSC_DIV_W-1:0] FAST_2M_DIV = OSC_DIV_W'(CLK_FREQ_HZ / FAST_2M_HZ);
    localparam logic [OSC_DIV_W-1:0] FAST_4M_DIV = OSC_DIV_W'(CLK_FREQ_HZ / FAST_4M_HZ);
    localparam logic [OSC_DIV_W-1:0] FAST_8M_DIV = OSC_DIV_W'(CLK_FREQ_HZ / FAST_8M_HZ);
    localparam logic [OSC_DIV_W-1:0] SLOW_OSC_DIV = OSC_DIV_W'(CLK_FREQ_HZ / SLOW_OSC_HZ);

    // =========================================================
    // fast oscillator start-up time, least time so rounded up
    localparam int unsigned FAST_OSC_SETTLE_NS = 1000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned FAST_OSC_SETTLE_CYC =
        (FAST_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W = 12;

    // =========================================================
    // field encodings and reset values
    localparam logic [2:0] SEL_SUB_CLK = 3'h7;
    localparam logic [1:0] FREQ_2M = 2'h0;
    localparam logic [1:0] FREQ_4M = 2'h1;
    localparam logic [1:0] FREQ_8M = 2'h2;
    localparam logic [1:0] FREQ_SEL_RESET = 2'h0;

    // one-hot operating mode as reported outward
    localparam int unsigned MODE_FAST = 0;
    localparam int unsigned MODE_SLOW = 1;
    localparam int unsigned MODE_SLEEP = 2;
    localparam int unsigned MODE_IDLE_SUB = 3;
    localparam int unsigned MODE_IDLE_BOTH = 4;
    localparam int unsigned MODE_IDLE_FAST = 5;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP = 5'h02,
        ST_IDLE_SUB = 5'h04,
        ST_IDLE_BOTH = 5'h08,
        ST_IDLE_FAST = 5'h10
    } power_state_t;

endpackage : clk_mode_pkg

/* rtl/osc_if.sv */
// control and tick of one emulated oscillator
`timescale 1ns/1ps
interface osc_if
    import clk_mode_pkg::*;
();
    logic run;
    logic [OSC_DIV_W-1:0] period;
    logic tick;

    modport gen (input run, input period, output tick);
    modport ctrl (output run, output period, input tick);
endinterface : osc_if

/* rtl/osc_tick_gen.sv */
// emulated oscillator: one-cycle tick every period cycles while running
`timescale 1ns/1ps
module osc_tick_gen
    import clk_mode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    osc_if.gen osc
);

    logic [OSC_DIV_W-1:0] count_reg;
    logic tick_reg;

    // =========================================================
    // counter
    always_ff @(posedge clk)
    begin
        if (sys_rst || !osc.run)
        begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (count_reg >= osc.period - OSC_DIV_W'(1))
        begin
            count_reg <= '0;
            tick_reg <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + OSC_DIV_W'(1);
            tick_reg <= 1'b0;
        end
    end

    assign osc.tick = tick_reg;

endmodule : osc_tick_gen

/* rtl/clk_mode_ctrl.sv */
// system clock selection and cpu-off power mode controller
`timescale 1ns/1ps
module clk_mode_ctrl
    import clk_mode_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = FAST_OSC_SETTLE_CYC
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] sysclk_select,
    input wire logic fast_osc_keep_on_halt,
    input wire logic slow_osc_keep_on_halt,
    input wire logic [1:0] fast_osc_freq_sel,
    input wire logic fast_osc_enable,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic power_down_flag_clear,
    output logic fast_osc_stable_flag,
    output logic power_down_flag,
    output logic watchdog_timeout_flag_clear,
    output logic watchdog_timer_clear,
    output logic cpu_run,
    output logic [5:0] op_mode,
    output logic sys_clk_en,
    output logic fast_clk_en,
    output logic sub_clk_en,
    output logic slow_osc_clk_en,
    output logic watchdog_clk_en,
    output logic timebase_clk_en
);

    power_state_t state_reg;
    power_state_t state_next;
    logic halted;
    logic sel_is_sub;
    logic fast_osc_on;
    logic fast_on_reg;
    logic [1:0] freq_req_reg;
    logic [1:0] freq_applied_reg;
    logic [SETTLE_W-1:0] settle_reg;
    logic stable_reg;
    logic had_clock_reg;
    logic [5:0] div_count_reg;
    logic [5:0] div_limit;
    logic fast_tick_ok;
    logic sys_tick;
    logic sys_run;
    logic sub_run;
    logic pdf_reg;

    osc_if fast_osc ();
    osc_if slow_osc ();

    // =========================================================
    // power state
    assign sel_is_sub = (sysclk_select == SEL_SUB_CLK);
    // cpu is off in every state but run
    assign halted = (state_reg != ST_RUN);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (halt_req)
                begin
                    case ({fast_osc_keep_on_halt, slow_osc_keep_on_halt})
                        2'b00: state_next = ST_SLEEP;
                        2'b01: state_next = ST_IDLE_SUB;
                        2'b11: state_next = ST_IDLE_BOTH;
                        default: state_next = ST_IDLE_FAST;
                    endcase
                end
            end
            ST_SLEEP, ST_IDLE_SUB, ST_IDLE_BOTH, ST_IDLE_FAST:
            begin
                if (wake_req)
                begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // power-down side effects
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pdf_reg <= 1'b0;
            watchdog_timeout_flag_clear <= 1'b0;
            watchdog_timer_clear <= 1'b0;
        end
        else
        begin
            // set wins over a clear in the same cycle
            // a halt while already halted is refused, so only a taken halt counts
            if (!halted && halt_req)
            begin
                pdf_reg <= 1'b1;
            end
            else if (power_down_flag_clear)
            begin
                pdf_reg <= 1'b0;
            end
            watchdog_timeout_flag_clear <= !halted && halt_req;
            watchdog_timer_clear <= !halted && halt_req;
        end
    end

    assign power_down_flag = pdf_reg;

    // =========================================================
    // fast oscillator enable and settling
    always_comb
    begin
        case (state_reg)
            ST_RUN: fast_osc_on = !sel_is_sub || fast_osc_enable;
            ST_IDLE_BOTH, ST_IDLE_FAST: fast_osc_on = 1'b1;
            default: fast_osc_on = 1'b0;
        endcase
    end

    // new frequency only takes effect once the oscillator reports stable
    // flag drops while off, so software must wait again after a re-enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fast_on_reg <= 1'b0;
            freq_req_reg <= FREQ_SEL_RESET;
            freq_applied_reg <= FREQ_SEL_RESET;
            settle_reg <= '0;
            stable_reg <= 1'b0;
            had_clock_reg <= 1'b0;
        end
        else
        begin
            fast_on_reg <= fast_osc_on;
            freq_req_reg <= fast_osc_freq_sel;
            if (!fast_osc_on)
            begin
                stable_reg <= 1'b0;
                had_clock_reg <= 1'b0;
                settle_reg <= '0;
            end
            else if (!fast_on_reg || fast_osc_freq_sel != freq_req_reg)
            begin
                stable_reg <= 1'b0;
                settle_reg <= '0;
            end
            else if (!stable_reg)
            begin
                if (settle_reg >= SETTLE_W'(SETTLE_CYC - 1))
                begin
                    stable_reg <= 1'b1;
                    had_clock_reg <= 1'b1;
                    freq_applied_reg <= freq_req_reg;
                end
                else
                begin
                    settle_reg <= settle_reg + SETTLE_W'(1);
                end
            end
        end
    end

    assign fast_osc_stable_flag = stable_reg;

    // =========================================================
    // oscillator emulation
    always_comb
    begin
        case (freq_applied_reg)
            FREQ_4M: fast_osc.period = FAST_4M_DIV;
            FREQ_8M: fast_osc.period = FAST_8M_DIV;
            default: fast_osc.period = FAST_2M_DIV;
        endcase
    end

    // old frequency keeps running through a change; a cold start waits
    assign fast_osc.run = fast_osc_on && had_clock_reg;
    assign slow_osc.period = SLOW_OSC_DIV;
    assign slow_osc.run = 1'b1;

    osc_tick_gen fast_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .osc(fast_osc)
    );

    osc_tick_gen slow_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .osc(slow_osc)
    );

    // =========================================================
    // system clock divider
    assign div_limit = 6'((7'h01 << sysclk_select) - 7'h01);
    assign fast_tick_ok = fast_osc.tick && (div_count_reg >= div_limit);

    always_ff @(posedge clk)
    begin
        if (sys_rst || sel_is_sub)
        begin
            div_count_reg <= '0;
        end
        else if (fast_osc.tick)
        begin
            div_count_reg <= fast_tick_ok ? 6'h00 : div_count_reg + 6'h01;
        end
    end

    always_comb
    begin
        case (state_reg)
            ST_RUN, ST_IDLE_BOTH: sys_run = 1'b1;
            ST_IDLE_SUB: sys_run = sel_is_sub;
            ST_IDLE_FAST: sys_run = !sel_is_sub;
            default: sys_run = 1'b0;
        endcase
    end

    assign sub_run = (state_reg == ST_RUN) || (state_reg == ST_IDLE_SUB)
        || (state_reg == ST_IDLE_BOTH);
    assign sys_tick = sel_is_sub ? slow_osc.tick : fast_tick_ok;

    // =========================================================
    // registered clock enables and status
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sys_clk_en <= 1'b0;
            fast_clk_en <= 1'b0;
            sub_clk_en <= 1'b0;
            slow_osc_clk_en <= 1'b0;
            watchdog_clk_en <= 1'b0;
            timebase_clk_en <= 1'b0;
            cpu_run <= 1'b0;
            op_mode <= 6'h00;
        end
        else
        begin
            sys_clk_en <= sys_run && sys_tick;
            fast_clk_en <= fast_osc.tick;
            sub_clk_en <= sub_run && slow_osc.tick;
            slow_osc_clk_en <= slow_osc.tick;
            watchdog_clk_en <= slow_osc.tick;
            timebase_clk_en <= sub_run && slow_osc.tick;
            cpu_run <= (state_next == ST_RUN);
            op_mode <= 6'h00;
            case (state_next)
                ST_RUN: op_mode[sel_is_sub ? MODE_SLOW : MODE_FAST] <= 1'b1;
                ST_SLEEP: op_mode[MODE_SLEEP] <= 1'b1;
                ST_IDLE_SUB: op_mode[MODE_IDLE_SUB] <= 1'b1;
                ST_IDLE_BOTH: op_mode[MODE_IDLE_BOTH] <= 1'b1;
                ST_IDLE_FAST: op_mode[MODE_IDLE_FAST] <= 1'b1;
                default: op_mode <= 6'h00;
            endcase
        end
    end

endmodule : clk_mode_ctrl

/* verif/cpu_core_model.sv */
// cpu core model: raises halt requests with keep bits
`timescale 1ns/1ps
module cpu_core_model
(
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] keep_in,
    output logic halt_req,
    output logic fast_osc_keep_on_halt,
    output logic slow_osc_keep_on_halt
);
    // ====
    // one-cycle halt; keep bits land with it and then stay
    always @(posedge clk)
    begin
        halt_req <= go;
        if (go)
            {fast_osc_keep_on_halt, slow_osc_keep_on_halt} <= keep_in;
    end
endmodule : cpu_core_model

/* verif/clk_mode_ctrl_checker.sv */
// assertions on the clock and power mode controller ports
`timescale 1ns/1ps
module clk_mode_ctrl_checker
    import clk_mode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic power_down_flag_clear,
    input wire logic fast_osc_keep_on_halt,
    input wire logic slow_osc_keep_on_halt,
    input wire logic fast_osc_enable,
    input wire logic [2:0] sysclk_select,
    input wire logic [1:0] fast_osc_freq_sel,
    input wire logic fast_osc_stable_flag,
    input wire logic power_down_flag,
    input wire logic cpu_run,
    input wire logic watchdog_timeout_flag_clear,
    input wire logic watchdog_timer_clear,
    input wire logic [5:0] op_mode,
    input wire logic sys_clk_en,
    input wire logic fast_clk_en,
    input wire logic sub_clk_en,
    input wire logic slow_osc_clk_en,
    input wire logic watchdog_clk_en,
    input wire logic timebase_clk_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [10:0] slow_gap_reg;
    logic [5:0] want;
    logic f, s;
    // ====
    // helpers
    assign f = fast_osc_keep_on_halt;
    assign s = slow_osc_keep_on_halt;
    assign want = {f & ~s, f & s, ~f & s, ~f & ~s, 2'h0};
    // watchdog source must never go quiet, whatever the mode
    always_ff @(posedge clk)
        slow_gap_reg <= (sys_rst || (slow_osc_clk_en && watchdog_clk_en)) ? 11'h0
            : slow_gap_reg + 11'h1;
    sequence halt_taken;
        halt_req && cpu_run;
    endsequence
    sequence halt_entry;
        !cpu_run && power_down_flag && watchdog_timer_clear && watchdog_timeout_flag_clear;
    endsequence
    // ====
    // assertions
    mode_from_keep_a: assert property (halt_taken |=> op_mode == $past(want))
        else $error("halt mode wrong");
    halt_side_a: assert property (halt_taken |=> halt_entry ##1 !watchdog_timer_clear)
        else $error("halt entry effects wrong");
    pdf_sticky_a: assert property (power_down_flag && !power_down_flag_clear
        |=> power_down_flag)
        else $error("power down flag lost");
    mode_onehot_a: assert property (op_mode != 6'h0
        |-> $onehot(op_mode) && cpu_run == |op_mode[1:0])
        else $error("mode not one of six");
    sleep_quiet_a: assert property (op_mode[2] && $past(op_mode[2], 2)
        |-> !(sys_clk_en || fast_clk_en || sub_clk_en || timebase_clk_en))
        else $error("clock runs in sleep");
    run_sub_a: assert property ($past(cpu_run) |-> sub_clk_en == slow_osc_clk_en
        && timebase_clk_en == slow_osc_clk_en)
        else $error("sub clock gated in run");
    slow_alive_a: assert property (slow_gap_reg <= 11'h514)
        else $error("slow oscillator stopped");
    sub_idle_a: assert property (op_mode[3] && $past(op_mode[3], 2)
        |-> !fast_clk_en && (!sys_clk_en || sysclk_select == SEL_SUB_CLK))
        else $error("idle sub clocks wrong");
    fast_idle_a: assert property (op_mode[5] && $past(op_mode[5], 2)
        |-> !sub_clk_en && !timebase_clk_en && (!sys_clk_en || sysclk_select != SEL_SUB_CLK))
        else $error("idle fast clocks wrong");
    freq_change_a: assert property (op_mode[0] && fast_osc_stable_flag
        && $changed(fast_osc_freq_sel) |-> ##[1:2] !fast_osc_stable_flag)
        else $error("stable flag kept on change");
endmodule : clk_mode_ctrl_checker

bind clk_mode_ctrl clk_mode_ctrl_checker clk_mode_ctrl_checker_inst (.clk(clk), .sys_rst(sys_rst),
    .halt_req(halt_req), .wake_req(wake_req), .power_down_flag_clear(power_down_flag_clear),
    .fast_osc_keep_on_halt(fast_osc_keep_on_halt),
    .slow_osc_keep_on_halt(slow_osc_keep_on_halt), .fast_osc_enable(fast_osc_enable),
    .sysclk_select(sysclk_select), .fast_osc_freq_sel(fast_osc_freq_sel),
    .fast_osc_stable_flag(fast_osc_stable_flag), .power_down_flag(power_down_flag),
    .cpu_run(cpu_run), .watchdog_timeout_flag_clear(watchdog_timeout_flag_clear),
    .watchdog_timer_clear(watchdog_timer_clear), .op_mode(op_mode),
    .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en), .sub_clk_en(sub_clk_en),
    .slow_osc_clk_en(slow_osc_clk_en), .watchdog_clk_en(watchdog_clk_en),
    .timebase_clk_en(timebase_clk_en));

/* verif/system_clock_power_mode_control_test.sv */
// self-checking bench for the clock and power mode controller
`timescale 1ns/1ps
module system_clock_power_mode_control_test
    import clk_mode_pkg::*;
;
    logic clk, sys_rst, wake_req, power_down_flag_clear, fast_osc_enable, go;
    logic fast_osc_keep_on_halt, slow_osc_keep_on_halt, halt_req;
    logic fast_osc_stable_flag, power_down_flag, cpu_run, sys_clk_en, fast_clk_en;
    logic [2:0] sysclk_select;
    logic [1:0] fast_osc_freq_sel, keep_in;
    logic [5:0] op_mode;
    logic [15:0] sc = 16'h0, fc = 16'h0, sys_gap = 16'h0, fast_gap = 16'h0, n_fast = 16'h0;
    logic [5:0] halt_tbl [4] = '{6'h04, 6'h08, 6'h20, 6'h10};
    int mismatches, checks, k, f;
    // ====
    // design and cpu model; short settle keeps the run brief
    clk_mode_ctrl #(.SETTLE_CYC(8)) clk_mode_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
        .sysclk_select(sysclk_select), .fast_osc_keep_on_halt(fast_osc_keep_on_halt),
        .slow_osc_keep_on_halt(slow_osc_keep_on_halt), .fast_osc_freq_sel(fast_osc_freq_sel),
        .fast_osc_enable(fast_osc_enable), .halt_req(halt_req), .wake_req(wake_req),
        .power_down_flag_clear(power_down_flag_clear),
        .fast_osc_stable_flag(fast_osc_stable_flag), .power_down_flag(power_down_flag),
        .watchdog_timeout_flag_clear(), .watchdog_timer_clear(), .cpu_run(cpu_run),
        .op_mode(op_mode), .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en),
        .sub_clk_en(), .slow_osc_clk_en(), .watchdog_clk_en(), .timebase_clk_en());
    cpu_core_model cpu_core_model_inst (.clk(clk), .go(go), .keep_in(keep_in),
        .halt_req(halt_req), .fast_osc_keep_on_halt(fast_osc_keep_on_halt),
        .slow_osc_keep_on_halt(slow_osc_keep_on_halt));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // gaps between enable pulses, in clk cycles
    always @(posedge clk)
    begin
        sc <= sys_clk_en ? 16'h1 : sc + 16'h1;
        fc <= fast_clk_en ? 16'h1 : fc + 16'h1;
        if (sys_clk_en) sys_gap <= sc;
        if (fast_clk_en) fast_gap <= fc;
        n_fast <= n_fast + 16'(fast_clk_en);
    end
    // ====
    // helpers
    function automatic logic [15:0] fast_per(input logic [1:0] fs);
        return fs == FREQ_4M ? 16'(FAST_4M_DIV)
            : fs == FREQ_8M ? 16'(FAST_8M_DIV) : 16'(FAST_2M_DIV);
    endfunction : fast_per
    function automatic logic [15:0] sys_per(input logic [2:0] sl, input logic [1:0] fs);
        return sl == SEL_SUB_CLK ? 16'(SLOW_OSC_DIV) : fast_per(fs) << sl;
    endfunction : sys_per
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task wait_flag;
        for (int i = 0; i < 200 && fast_osc_stable_flag !== 1'b1; i++)
            @(posedge clk);
        #1;
    endtask : wait_flag
    task results;
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    initial
    begin
        tick(40000);
        mismatches++;
        results();
    end
    // ====
    // tests
    initial
    begin
        {sys_rst, fast_osc_enable} = 2'h3;
        {wake_req, power_down_flag_clear, go, keep_in} = 5'h0;
        {sysclk_select, fast_osc_freq_sel} = 5'h0;
        void'($urandom(7));
        tick(3);
        sys_rst <= 1'b0;
        tick(2);
        #1 chk("op_mode", 16'h1, 16'(op_mode));
        wait_flag();
        chk("stable", 16'h1, 16'(fast_osc_stable_flag));
        $display("test reset done");
        // slow select and the largest divider forced, the rest random
        for (f = 1; f < 5; f++)
        begin
            tick(1);
            fast_osc_freq_sel <= 2'(f);
            sysclk_select <= f == 1 ? 3'h7 : f == 4 ? 3'h6 : 3'($urandom % 6);
            tick(3);
            #1 chk("stable", 16'h0, 16'(fast_osc_stable_flag));
            wait_flag();
            chk("stable", 16'h1, 16'(fast_osc_stable_flag));
            tick(2 * int'(sys_per(sysclk_select, fast_osc_freq_sel)) + 4);
            #1 chk("fast gap", fast_per(fast_osc_freq_sel), fast_gap);
            chk("sys gap", sys_per(sysclk_select, fast_osc_freq_sel), sys_gap);
            chk("op_mode", sysclk_select == SEL_SUB_CLK ? 16'h2 : 16'h1, 16'(op_mode));
            $display("test freq %0d done", f);
        end
        for (k = 0; k < 4; k++)
        begin
            tick(1);
            keep_in <= 2'(k);
            sysclk_select <= 3'($urandom % 8);
            go <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(2);
            #1 chk("op_mode", 16'(halt_tbl[k]), 16'(op_mode));
            chk("pdf", 16'h1, 16'(power_down_flag));
            tick(300);
            wake_req <= 1'b1;
            tick(1);
            wake_req <= 1'b0;
            power_down_flag_clear <= 1'b1;
            tick(1);
            power_down_flag_clear <= 1'b0;
            tick(1);
            #1 chk("cpu_run", 16'h1, 16'(cpu_run));
            chk("pdf", 16'h0, 16'(power_down_flag));
            $display("test halt %0d done", k);
        end
        tick(1);
        sysclk_select <= SEL_SUB_CLK;
        fast_osc_enable <= 1'b0;
        tick(20);
        k = int'(n_fast);
        tick(200);
        #1 chk("fast pulses", 16'(k), n_fast);
        tick(1);
        fast_osc_enable <= 1'b1;
        tick(3);
        wait_flag();
        chk("stable", 16'h1, 16'(fast_osc_stable_flag));
        $display("test slow enable done");
        results();
    end
endmodule : system_clock_power_mode_control_test
